// file: reading_pkg.sv
// Constants, field layouts and carrier types for the pressure reading path
package reading_pkg;

  // Clock and timing
  localparam int CLK_HZ           = 125_000_000;
  localparam int SAMPLE_PERIOD_MS = 20;
  localparam int SAMPLE_CYCLES    = CLK_HZ / 1000 * SAMPLE_PERIOD_MS;
  localparam int BAUD_RATE        = 9600;
  localparam int BAUD_CYCLES      = CLK_HZ / BAUD_RATE;

  // Data widths
  localparam int RAW_W      = 24;
  localparam int SMOOTH_W   = 7;
  localparam int UART_BITS  = 8;

  // Filter constants
  localparam logic [SMOOTH_W-1:0] SMOOTH_MAX   = 7'h63;  // 99
  localparam logic [SMOOTH_W-1:0] SMOOTH_RESET = 7'h5a;  // 90
  localparam logic [SMOOTH_W-1:0] PERCENT_FULL = 7'h64;  // 100
  localparam int BYPASS_FS_DIVISOR = 5000;               // 0.02 % of full scale

  // Address and protocol characters
  localparam logic [7:0] ADDR_RESET  = 8'h31;  // '1'
  localparam logic [7:0] CH_HASH     = 8'h23;
  localparam logic [7:0] CH_STAR     = 8'h2a;
  localparam logic [7:0] CH_QUERY    = 8'h3f;
  localparam logic [7:0] CH_DOT      = 8'h2e;
  localparam logic [7:0] CH_CR       = 8'h0d;
  localparam logic [7:0] CH_LF       = 8'h0a;
  localparam logic [7:0] CH_SPACE    = 8'h20;
  localparam logic [7:0] CH_0        = 8'h30;
  localparam logic [7:0] CH_9        = 8'h39;
  localparam logic [7:0] CH_UA       = 8'h41;
  localparam logic [7:0] CH_UZ       = 8'h5a;
  localparam logic [7:0] CH_LA       = 8'h61;
  localparam logic [7:0] CH_LZ       = 8'h7a;
  localparam logic [7:0] CASE_BIT    = 8'h20;

  // Reply framing: address, space, eight hex digits, CR, LF
  localparam logic [3:0] REPLY_LAST  = 4'hb;
  localparam logic [3:0] FRAME_LAST  = 4'h9;

  // APB byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_RANGE0  = 8'h04;
  localparam logic [7:0] OFF_RANGE1  = 8'h08;
  localparam logic [7:0] OFF_FS0     = 8'h0c;
  localparam logic [7:0] OFF_FS1     = 8'h10;
  localparam logic [7:0] OFF_READING = 8'h14;
  localparam logic [7:0] OFF_STATUS  = 8'h18;

  // Range register field positions
  localparam int ADDR_LSB   = 0;
  localparam int SMOOTH_LSB = 8;

  // Full scale reset: whole converter span
  localparam logic [RAW_W-1:0] FS_RESET = 24'hffffff;

  // Per-range settings travel together
  typedef struct packed {
    logic [RAW_W-1:0]    full_scale;
    logic [SMOOTH_W-1:0] smoothing_percent;
    logic [7:0]          station_addr;
  } range_cfg_t;

  // One received serial character
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rx_char_t;

endpackage : reading_pkg

// file: serial_rx.sv
// Asynchronous serial receiver, 8 data bits, no parity, 1 stop bit
module serial_rx #(
  parameter int DIV = reading_pkg::BAUD_CYCLES
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // Line
  input  wire logic                  rxd,
  // Received character, valid for one cycle
  output reading_pkg::rx_char_t      rx_char
);
  import reading_pkg::*;

  logic [15:0] div_reg;    // Baud divider
  logic [3:0]  bit_reg;    // 0 start, 1..8 data, 9 stop
  logic        busy_reg;   // Frame in progress
  logic [7:0]  shift_reg;  // Data bits, lsb first
  rx_char_t    out_reg;    // Character to the parser

  localparam logic [15:0] DIV_LAST = 16'(DIV - 1);
  localparam logic [15:0] DIV_HALF = 16'(DIV / 2);

  // Sampling at mid-bit keeps margin for clock mismatch at either end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg   <= 16'h0000;
      bit_reg   <= 4'h0;
      busy_reg  <= 1'b0;
      shift_reg <= 8'h00;
      out_reg   <= '0;
    end else begin
      out_reg.valid <= 1'b0;
      if (!busy_reg) begin
        // Wait for the start edge, then aim at its middle
        if (!rxd) begin
          busy_reg <= 1'b1;
          bit_reg  <= 4'h0;
          div_reg  <= DIV_HALF;
        end
      end else if (div_reg != 16'h0000) begin
        div_reg <= div_reg - 16'h0001;
      end else begin
        div_reg <= DIV_LAST;
        if (bit_reg == 4'h0) begin
          // False start: glitch is dropped
          if (rxd) begin
            busy_reg <= 1'b0;
          end
          bit_reg <= 4'h1;
        end else if (bit_reg <= 4'h8) begin
          shift_reg <= {rxd, shift_reg[7:1]};
          bit_reg   <= bit_reg + 4'h1;
        end else begin
          // Stop bit must be high or the character is discarded
          busy_reg     <= 1'b0;
          out_reg.valid <= rxd;
          out_reg.data  <= shift_reg;
        end
      end
    end
  end

  assign rx_char = out_reg;

endmodule : serial_rx

// file: pressure_reader.sv
// Pressure sampling, smoothing filter, address matching and APB registers
//
// The address map and the APB interface to the registers were decided locally.
module pressure_reader #(
  parameter int SAMPLE_CYC = reading_pkg::SAMPLE_CYCLES,
  parameter int BAUD_CYC   = reading_pkg::BAUD_CYCLES
) (
  // APB clock and reset
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  // APB slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [7:0]                     paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  // Sensor converter
  input  wire logic [reading_pkg::RAW_W-1:0]  raw_pressure,
  output logic                                sample_take,
  output logic      [reading_pkg::RAW_W-1:0]  reading,
  // Serial line
  input  wire logic                           rxd,
  output logic                                txd
);
  import reading_pkg::*;

  typedef enum logic [3:0] {
    P_IDLE = 4'b0001,   // Waiting for '#'
    P_ADDR = 4'b0010,   // Next significant char is address
    P_BODY = 4'b0100,   // Command body
    P_SKIP = 4'b1000    // Foreign address, wait for end
  } parse_t;

  localparam logic [31:0] TICK_LAST = 32'(SAMPLE_CYC - 1);
  localparam logic [15:0] BAUD_LAST = 16'(BAUD_CYC - 1);

  range_cfg_t         cfg_reg [2];        // Settings per range
  logic               range_reg;          // Active range
  logic [31:0]        tick_reg;           // Sample period counter
  logic               tick_reg_q;         // Sample strobe
  logic [RAW_W-1:0]   hist_reg;           // Shared filter history
  logic               seeded_reg;         // History holds a sample
  logic               bypass_reg;         // Last sample skipped filter
  logic               pready_reg;
  logic [31:0]        prdata_reg;
  logic               pslverr_reg;
  rx_char_t           rx_char;
  parse_t             pst_reg;
  logic               addr_hit_reg;       // Address matched this frame
  logic               q_seen_reg;         // Query mark seen
  logic               other_reg;          // Other significant text seen
  logic               tx_busy_reg;
  logic [3:0]         tx_idx_reg;         // Reply byte index
  logic [3:0]         tx_bit_reg;         // Bit within frame
  logic [15:0]        tx_div_reg;
  logic [9:0]         tx_shift_reg;
  logic [31:0]        tx_val_reg;         // Reading latched for reply, zero-extended to 8 digits
  logic [7:0]         tx_addr_reg;        // Address latched for reply
  logic               txd_reg;

  // Active range settings and filter arithmetic
  range_cfg_t         act;
  logic [RAW_W-1:0]   thr;
  logic [RAW_W-1:0]   diff;
  logic               bypass;
  logic [30:0]        acc;
  logic [RAW_W-1:0]   filt;
  logic               query_end;

  function automatic logic [7:0] upcase(input logic [7:0] c);
    upcase = (c >= CH_LA && c <= CH_LZ) ? (c & ~CASE_BIT) : c;
  endfunction : upcase

  function automatic logic is_alnum(input logic [7:0] c);
    is_alnum = (c >= CH_0 && c <= CH_9) || (c >= CH_UA && c <= CH_UZ);
  endfunction : is_alnum

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'ha) ? (CH_0 + {4'h0, n}) : (CH_UA + {4'h0, n - 4'ha});
  endfunction : hex_char

  // Serial receiver
  serial_rx #(.DIV(BAUD_CYC)) u_rx (
    .pclk    (pclk),
    .presetn (presetn),
    .rxd     (rxd),
    .rx_char (rx_char)
  );

  // Filter: threshold from the active range's own full scale
  always_comb begin
    act    = cfg_reg[range_reg];
    thr    = RAW_W'(act.full_scale / BYPASS_FS_DIVISOR);
    diff   = (raw_pressure > hist_reg) ? raw_pressure - hist_reg : hist_reg - raw_pressure;
    // Zero setting, a large step or an empty history pass raw through
    bypass = !seeded_reg || (act.smoothing_percent == 7'h00) || (diff > thr);
    acc    = 31'(act.smoothing_percent) * 31'(hist_reg)
           + 31'(PERCENT_FULL - act.smoothing_percent) * 31'(raw_pressure);
    filt   = RAW_W'(acc / 31'(PERCENT_FULL));
  end

  // Sample timebase, free running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_reg   <= 32'h0;
      tick_reg_q <= 1'b0;
    end else begin
      tick_reg_q <= (tick_reg == TICK_LAST);
      tick_reg   <= (tick_reg == TICK_LAST) ? 32'h0 : tick_reg + 32'h1;
    end
  end

  // Filter history: one store serves both ranges, so a switch carries it over
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_reg   <= '0;
      seeded_reg <= 1'b0;
      bypass_reg <= 1'b0;
    end else if (tick_reg_q) begin
      hist_reg   <= bypass ? raw_pressure : filt;
      seeded_reg <= 1'b1;
      bypass_reg <= bypass;
    end
  end

  // APB: one wait state, so read data comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end else if (psel && penable && !pready_reg) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
      if (paddr == OFF_CTRL) begin
        prdata_reg <= {31'h0, range_reg};
      end else if (paddr == OFF_RANGE0) begin
        prdata_reg <= {17'h0, cfg_reg[0].smoothing_percent, cfg_reg[0].station_addr};
      end else if (paddr == OFF_RANGE1) begin
        prdata_reg <= {17'h0, cfg_reg[1].smoothing_percent, cfg_reg[1].station_addr};
      end else if (paddr == OFF_FS0) begin
        prdata_reg <= {8'h0, cfg_reg[0].full_scale};
      end else if (paddr == OFF_FS1) begin
        prdata_reg <= {8'h0, cfg_reg[1].full_scale};
      end else if (paddr == OFF_READING) begin
        prdata_reg <= {8'h0, hist_reg};
      end else if (paddr == OFF_STATUS) begin
        prdata_reg <= {29'h0, tx_busy_reg, bypass_reg, seeded_reg};
      end else begin
        // Unmapped: error, reads zero
        pslverr_reg <= 1'b1;
      end
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // Register writes take effect at the completing edge; bad values are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_reg <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        cfg_reg[i].station_addr      <= ADDR_RESET;
        cfg_reg[i].smoothing_percent <= SMOOTH_RESET;
        cfg_reg[i].full_scale        <= FS_RESET;
      end
    end else if (psel && penable && pready_reg && pwrite && !pslverr_reg) begin
      if (paddr == OFF_CTRL) begin
        range_reg <= pwdata[0];
      end else if (paddr == OFF_RANGE0 || paddr == OFF_RANGE1) begin
        // Each range written alone
        if (is_alnum(upcase(pwdata[ADDR_LSB +: 8]))) begin
          cfg_reg[paddr == OFF_RANGE1].station_addr <= upcase(pwdata[ADDR_LSB +: 8]);
        end
        if (pwdata[SMOOTH_LSB +: SMOOTH_W] <= SMOOTH_MAX) begin
          cfg_reg[paddr == OFF_RANGE1].smoothing_percent <= pwdata[SMOOTH_LSB +: SMOOTH_W];
        end
      end else if (paddr == OFF_FS0) begin
        cfg_reg[0].full_scale <= pwdata[RAW_W-1:0];
      end else if (paddr == OFF_FS1) begin
        cfg_reg[1].full_scale <= pwdata[RAW_W-1:0];
      end
    end
  end

  // Frame end in the command body of a frame addressed to us
  assign query_end = rx_char.valid && (pst_reg == P_BODY)
                   && (rx_char.data == CH_CR || rx_char.data == CH_LF);

  // Command parser; punctuation other than '?' and '.' is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pst_reg      <= P_IDLE;
      addr_hit_reg <= 1'b0;
      q_seen_reg   <= 1'b0;
      other_reg    <= 1'b0;
    end else if (rx_char.valid) begin
      if (rx_char.data == CH_HASH) begin
        pst_reg      <= P_ADDR;
        addr_hit_reg <= 1'b0;
        q_seen_reg   <= 1'b0;
        other_reg    <= 1'b0;
      end else if (rx_char.data == CH_CR || rx_char.data == CH_LF) begin
        pst_reg <= P_IDLE;
      end else begin
        case (pst_reg)
          P_ADDR: begin
            if (rx_char.data == CH_STAR
                || upcase(rx_char.data) == act.station_addr) begin
              pst_reg      <= P_BODY;
              addr_hit_reg <= 1'b1;
            end else if (is_alnum(upcase(rx_char.data))) begin
              pst_reg <= P_SKIP;
            end
          end
          P_BODY: begin
            if (rx_char.data == CH_QUERY) begin
              q_seen_reg <= 1'b1;
            end else if (is_alnum(upcase(rx_char.data)) || rx_char.data == CH_DOT) begin
              other_reg <= 1'b1;
            end
          end
          default: begin
            pst_reg <= pst_reg;
          end
        endcase
      end
    end
  end

  // Reply: address, space, hex reading, CR, LF; a query while busy is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_busy_reg  <= 1'b0;
      tx_idx_reg   <= 4'h0;
      tx_bit_reg   <= 4'h0;
      tx_div_reg   <= 16'h0;
      tx_shift_reg <= 10'h3ff;
      tx_val_reg   <= '0;
      tx_addr_reg  <= ADDR_RESET;
      txd_reg      <= 1'b1;
    end else if (!tx_busy_reg) begin
      txd_reg <= 1'b1;
      if (query_end && addr_hit_reg && q_seen_reg && !other_reg) begin
        tx_busy_reg  <= 1'b1;
        tx_idx_reg   <= 4'h0;
        tx_bit_reg   <= 4'h0;
        tx_div_reg   <= BAUD_LAST;
        tx_val_reg   <= {8'h00, hist_reg};
        tx_addr_reg  <= act.station_addr;
        tx_shift_reg <= {1'b1, act.station_addr, 1'b0};
      end
    end else begin
      txd_reg <= tx_shift_reg[0];
      if (tx_div_reg != 16'h0) begin
        tx_div_reg <= tx_div_reg - 16'h1;
      end else begin
        tx_div_reg <= BAUD_LAST;
        if (tx_bit_reg != FRAME_LAST) begin
          tx_bit_reg   <= tx_bit_reg + 4'h1;
          tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
        end else if (tx_idx_reg == REPLY_LAST) begin
          tx_busy_reg <= 1'b0;
        end else begin
          tx_bit_reg <= 4'h0;
          tx_idx_reg <= tx_idx_reg + 4'h1;
          if (tx_idx_reg == 4'h0) begin
            tx_shift_reg <= {1'b1, CH_SPACE, 1'b0};
          end else if (tx_idx_reg <= 4'h8) begin
            // Hex digits, most significant nibble first
            tx_shift_reg <= {1'b1, hex_char(tx_val_reg[(8'(8 - tx_idx_reg) * 4) +: 4]), 1'b0};
          end else if (tx_idx_reg == 4'h9) begin
            tx_shift_reg <= {1'b1, CH_CR, 1'b0};
          end else begin
            tx_shift_reg <= {1'b1, CH_LF, 1'b0};
          end
        end
      end
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign sample_take = tick_reg_q;
  assign reading     = hist_reg;
  assign txd         = txd_reg;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_tick_gap;
    tick_reg_q |=> !tick_reg_q [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("sample strobe too close");

  property p_zero_off;
    tick_reg_q && seeded_reg && act.smoothing_percent == 7'h00 |=> hist_reg == $past(raw_pressure);
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("zero smoothing filtered");

  property p_step_bypass;
    tick_reg_q && diff > thr |=> hist_reg == $past(raw_pressure) && bypass_reg;
  endproperty
  a_step_bypass: assert property (p_step_bypass) else $error("large step filtered");

  property p_blend_between;
    tick_reg_q && !bypass |=> (hist_reg >= $past(hist_reg) && hist_reg <= $past(raw_pressure))
                            || (hist_reg <= $past(hist_reg) && hist_reg >= $past(raw_pressure));
  endproperty
  a_blend_between: assert property (p_blend_between) else $error("blend outside bounds");

  property p_smooth_max;
    cfg_reg[0].smoothing_percent <= SMOOTH_MAX && cfg_reg[1].smoothing_percent <= SMOOTH_MAX;
  endproperty
  a_smooth_max: assert property (p_smooth_max) else $error("smoothing above limit");

  property p_addr_valid;
    is_alnum(cfg_reg[0].station_addr) && is_alnum(cfg_reg[1].station_addr);
  endproperty
  a_addr_valid: assert property (p_addr_valid) else $error("bad station address");

  property p_seed;
    tick_reg_q && !seeded_reg |=> seeded_reg && hist_reg == $past(raw_pressure);
  endproperty
  a_seed: assert property (p_seed) else $error("first sample not seeded");

  property p_ignore_foreign;
    rx_char.valid && (rx_char.data == CH_CR || rx_char.data == CH_LF)
      && !addr_hit_reg && !tx_busy_reg |=> !tx_busy_reg;
  endproperty
  a_ignore_foreign: assert property (p_ignore_foreign) else $error("replied to foreign frame");

  property p_reply_addr;
    $rose(tx_busy_reg) |-> tx_shift_reg[8:1] == tx_addr_reg && tx_addr_reg == act.station_addr;
  endproperty
  a_reply_addr: assert property (p_reply_addr) else $error("reply address wrong");

  property p_apb_wait;
    psel && penable && !pready_reg |=> pready_reg ##1 !pready_reg;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("APB answer timing");

  c_bypass:  cover property (tick_reg_q && seeded_reg && bypass);
  c_filter:  cover property (tick_reg_q && !bypass);
  c_reply:   cover property ($rose(tx_busy_reg));
  c_switch:  cover property ($changed(range_reg) ##[1:8] tick_reg_q);

endmodule : pressure_reader

// file: serial_host.sv
// Host computer model on the asynchronous serial line
module serial_host #(
  parameter int BAUD = 16
) (
  // Clock
  input  wire logic pclk,
  // Line from the device transmitter
  input  wire logic txd,
  // Line into the device receiver
  output logic      rxd
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] rxq[$];  // Characters heard from the device, oldest first

  // Line idles at mark level
  initial begin
    rxd = 1'b1;
  end

  // One 8N1 character: start, lsb first, stop; host TX feeds device RX
  task automatic send_char(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BAUD) @(posedge pclk);
    end
  endtask : send_char

  // Reading query to one address, pound first, carriage return last
  task automatic send_query(input logic [7:0] a);
    send_char(8'h23);
    send_char(a);
    send_char(8'h3f);
    send_char(8'h0d);
  endtask : send_query

  // Collect every reply character, sampled mid-bit at the same bit time
  always begin : collect
    logic [7:0] b;
    @(negedge txd);
    repeat (BAUD / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BAUD) @(posedge pclk);
      b[i] = txd;
    end
    repeat (BAUD) @(posedge pclk);
    // A broken stop bit spoils the character on purpose
    rxq.push_back((txd === 1'b1) ? b : 8'h00);
  end
endmodule : serial_host

// file: pressure_reader_test.sv
// Self-checking bench for the pressure reading path
module pressure_reader_test;
  timeunit 1ns;
  timeprecision 1ps;
  import reading_pkg::*;

  localparam int BAUD = 16;  // Shortened bit time keeps replies quick

  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic             rxd, txd, sample_take, err;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic [RAW_W-1:0] raw_pressure, reading;
  int               fails, n_checks, gap;

  pressure_reader #(.SAMPLE_CYC(200), .BAUD_CYC(BAUD)) pressure_reader_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .raw_pressure(raw_pressure), .sample_take(sample_take), .reading(reading),
    .rxd(rxd), .txd(txd));
  serial_host #(.BAUD(BAUD)) serial_host_i (.pclk(pclk), .txd(txd), .rxd(rxd));

  // Free-running 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Single place where the run ends
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // A wait that ran out is a mismatch
  task automatic stall();
    fails++;
    print_verdict();
  endtask : stall

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) stall();
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd, err);
    check(rd, exp);
  endtask : rd_chk

  // Present a raw code, wait for the strobe, then compare the reading
  task automatic sample(input logic [RAW_W-1:0] raw, input logic [RAW_W-1:0] exp);
    int n;
    @(posedge pclk);
    raw_pressure <= raw;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
      if (n > 250) stall();
    end while (sample_take !== 1'b1);
    @(negedge pclk);
    check(reading, exp);
  endtask : sample

  // Query an address; who of zero means silence is expected
  task automatic query(input logic [7:0] a, input logic [7:0] who, input logic [23:0] val);
    logic [31:0] v;
    logic [3:0]  nib;
    int          n;
    serial_host_i.rxq.delete();
    serial_host_i.send_query(a);
    v = {8'h00, val};
    if (who == 8'h00) begin
      repeat (40 * BAUD) @(posedge pclk);
      check(serial_host_i.rxq.size(), 32'h0);
    end else begin
      n = 0;
      while (serial_host_i.rxq.size() < 12) begin
        @(posedge pclk);
        n++;
        if (n > 2500) stall();
      end
      check(serial_host_i.rxq[0], who);
      check(serial_host_i.rxq[1], CH_SPACE);
      for (int i = 0; i < 8; i++) begin
        nib = v[31 - 4 * i -: 4];
        check(serial_host_i.rxq[2 + i], (nib < 4'ha) ? CH_0 + nib : CH_UA + nib - 8'h0a);
      end
      check(serial_host_i.rxq[10], CH_CR);
      check(serial_host_i.rxq[11], CH_LF);
    end
  endtask : query

  // Spacing of converter strobes, ignored until the first one after reset
  always @(posedge pclk) begin
    if (presetn !== 1'b1) gap = 0;
    else if (sample_take === 1'b1) begin
      if (gap > 0) check(gap, 32'h000000c8);
      gap = 1;
    end else if (gap > 0) gap++;
  end

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    raw_pressure = 24'h0003e8;
    fails = 0;
    n_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(OFF_CTRL, 32'h0);
    rd_chk(OFF_RANGE0, 32'h00005a31);
    rd_chk(OFF_RANGE1, 32'h00005a31);
    rd_chk(OFF_FS0, 32'h00ffffff);
    // Unmapped word answers with an error and zero data
    apb(1'b0, 8'h1c, 32'h0, rd, err);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    sample(24'h0003e8, 24'h0003e8);
    sample(24'h00044c, 24'h0003f2);
    sample(24'h002328, 24'h002328);
    // Threshold becomes exactly 100 codes
    wr(OFF_FS0, 32'h0007a120);
    sample(24'h00238c, 24'h002332);
    sample(24'h0023fb, 24'h0023fb);
    wr(OFF_RANGE0, 32'h00006431);
    rd_chk(OFF_RANGE0, 32'h00005a31);
    wr(OFF_RANGE0, 32'h00000031);
    sample(24'h002404, 24'h002404);
    query(8'h31, 8'h31, 24'h002404);
    query(8'h32, 8'h00, 24'h0);
    wr(OFF_RANGE1, 32'h00003262);
    rd_chk(OFF_RANGE1, 32'h00003242);
    wr(OFF_RANGE1, 32'h00007823);
    rd_chk(OFF_RANGE1, 32'h00003242);
    rd_chk(OFF_RANGE0, 32'h00000031);
    rd_chk(OFF_FS1, 32'h00ffffff);
    wr(OFF_CTRL, 32'h1);
    sample(24'h0024cc, 24'h002468);
    // Zero smoothing on the new range so replies stay steady
    wr(OFF_RANGE1, 32'h00000042);
    sample(24'h0024cc, 24'h0024cc);
    query(8'h31, 8'h00, 24'h0);
    query(8'h62, 8'h42, 24'h0024cc);
    query(CH_STAR, 8'h42, 24'h0024cc);
    // Extra text before the query mark makes it a command: no reply, LF ends it
    serial_host_i.rxq.delete();
    serial_host_i.send_char(CH_HASH);
    serial_host_i.send_char(8'h42);
    serial_host_i.send_char(8'h41);
    serial_host_i.send_char(CH_QUERY);
    serial_host_i.send_char(CH_LF);
    repeat (40 * BAUD) @(posedge pclk);
    check(serial_host_i.rxq.size(), 32'h0);
    // Zero smoothing: every sample bypasses, history seeded, no reply running
    rd_chk(OFF_STATUS, 32'h00000003);
    rd_chk(OFF_READING, 32'h000024cc);
    print_verdict();
  end
endmodule : pressure_reader_test
